// ---- hdl/pfs_pkg.sv ----
// shared constants and types for the program flow sequencer
package pfs_pkg;
    localparam int PC_W_DEF    = 12;
    localparam int INSTR_W     = 21;
    localparam int STACK_DEPTH = 8;

    // timing: clock rate and the watchdog time in milliseconds
    localparam int CLOCK_HZ    = 200_000_000;
    localparam int MS_PER_S    = 1000;
    localparam int MS_CYCLES   = CLOCK_HZ / MS_PER_S;
    localparam logic [15:0] WDT_DEFAULT_MS = 16'h00C8;

    // program limits
    localparam logic [7:0] MAX_JUMP      = 8'h80;
    localparam logic [7:0] MAX_LABEL     = 8'h40;
    localparam logic [7:0] MAX_LOOP      = 8'h40;
    localparam logic [7:0] MAX_CALL      = 8'h80;
    localparam logic [7:0] MAX_SUB_LABEL = 8'h40;

    // error codes
    localparam logic [15:0] ERR_NONE       = 16'h0000;
    localparam logic [15:0] ERR_WDT        = 16'h0003;
    localparam logic [15:0] ERR_SUB_LIMIT  = 16'h0412;
    localparam logic [15:0] ERR_LOOP_LIMIT = 16'h0413;
    localparam logic [15:0] ERR_END_BAD    = 16'h0415;
    localparam logic [15:0] ERR_JUMP_LIMIT = 16'h0417;

    typedef enum logic [3:0] {
        OP_NO_OPERATION     = 4'h0,
        OP_END              = 4'h1,
        OP_STOP             = 4'h2,
        OP_WATCHDOG_RESTART = 4'h3,
        OP_JUMP             = 4'h4,
        OP_JUMP_LABEL       = 4'h5,
        OP_LOOP_START       = 4'h6,
        OP_LOOP_END         = 4'h7,
        OP_SUBROUTINE_CALL  = 4'h8,
        OP_SUBROUTINE_LABEL = 4'h9,
        OP_SUBROUTINE_RETURN = 4'hA,
        OP_SUBROUTINE_RETURN_COND = 4'hB,
        OP_LOGIC            = 4'hF
    } pfs_op_e;

    typedef struct packed {
        pfs_op_e     op;
        logic        contact;
        logic [15:0] operand;
    } pfs_instr_s;

    typedef enum logic [2:0] {
        M_IDLE  = 3'b000,
        M_CHK_F = 3'b001,
        M_CHK_E = 3'b010,
        M_RUN_F = 3'b011,
        M_RUN_E = 3'b100
    } pfs_mode_e;

    typedef enum logic [1:0] {
        SK_NONE  = 2'b00,
        SK_LABEL = 2'b01,
        SK_LOOP  = 2'b10,
        SK_SUB   = 2'b11
    } pfs_skip_e;
endpackage : pfs_pkg

// ---- hdl/pfs_stack_if.sv ----
// return address stack connection between sequencer and stack
`timescale 1ns/1ps
interface pfs_stack_if #(parameter int AW = 12);
    logic          push;
    logic          pop;
    logic          clear;
    logic [AW-1:0] push_data;
    logic [AW-1:0] top;
    logic          full;
    logic          empty;
    modport owner (input push, pop, clear, push_data, output top, full, empty);
    modport user  (output push, pop, clear, push_data, input top, full, empty);
endinterface : pfs_stack_if

// ---- hdl/pfs_return_stack.sv ----
// last-in-first-out stack of subroutine return addresses
`timescale 1ns/1ps
module pfs_return_stack #(
    parameter int AW    = pfs_pkg::PC_W_DEF,
    parameter int DEPTH = pfs_pkg::STACK_DEPTH
)(
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    pfs_stack_if.owner  stk
);
    import pfs_pkg::*;
    localparam int SP_W = $clog2(DEPTH) + 1;

    typedef struct packed {
        logic [DEPTH-1:0][AW-1:0] slot;
        logic [SP_W-1:0]          sp;
    } pfs_stk_s;

    pfs_stk_s st;
    pfs_stk_s next_st;

    always_comb begin
        next_st = st;
        if (stk.clear) begin
            next_st.sp = '0;
        end else if (stk.push && !stk.full) begin
            next_st.slot[st.sp[SP_W-2:0]] = stk.push_data;
            next_st.sp = SP_W'(st.sp + 1'b1);
        end else if (stk.pop && !stk.empty) begin
            next_st.sp = SP_W'(st.sp - 1'b1);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign stk.empty = (st.sp == '0);
    assign stk.full  = (st.sp == SP_W'(DEPTH));
    assign stk.top   = stk.empty ? '0 : st.slot[SP_W'(st.sp - 1'b1)];

    chk_stack_push_top: assert property (@(posedge clk_i) disable iff (rst_i)
        stk.push && !stk.full && !stk.clear |=> stk.top == $past(stk.push_data))
        else $error("pushed address not on top");
endmodule : pfs_return_stack

// ---- hdl/pfs_sequencer.sv ----
// program flow sequencer: scan end, stop, watchdog, jumps, loops, subroutines
`timescale 1ns/1ps
module pfs_sequencer #(
    parameter int PC_W      = pfs_pkg::PC_W_DEF,
    parameter int MS_CYCLES = pfs_pkg::MS_CYCLES
)(
    input  wire logic                        CLOCK_I,
    input  wire logic                        SYS_RST_I,
    input  wire logic                        RUN_REQ_I,
    input  wire logic                        RUNG_TRUE_I,
    input  wire logic [pfs_pkg::INSTR_W-1:0] IMEM_DATA_I,
    input  wire logic                        CFG_CLEAR_I,
    input  wire logic                        WDT_CFG_WE_I,
    input  wire logic [15:0]                 WDT_CFG_MS_I,
    output logic      [PC_W-1:0]             IMEM_ADDR_O,
    output logic                             RUN_O,
    output logic                             EXEC_O,
    output logic                             SCAN_DONE_O,
    output logic                             IO_HOLD_O,
    output logic                             ERROR_O,
    output logic      [15:0]                 ERROR_CODE_O
);
    import pfs_pkg::*;

    localparam logic [PC_W-1:0] LAST_PC = '1;

    typedef struct packed {
        pfs_mode_e       mode;
        pfs_skip_e       skip;
        logic [PC_W-1:0] pc;
        logic [PC_W-1:0] end_addr;
        logic            end_found;
        logic            end_bad;
        logic [7:0]      cnt_jump;
        logic [7:0]      cnt_label;
        logic [7:0]      cnt_loop;
        logic [7:0]      cnt_call;
        logic [7:0]      cnt_sub;
        logic [15:0]     key;
        logic            in_loop;
        logic [PC_W-1:0] loop_start;
        logic [15:0]     loop_left;
        logic [31:0]     ms_div;
        logic [16:0]     scan_ms;
        logic [15:0]     wdt_ms;
        logic            run;
        logic            exec;
        logic            scan_done;
        logic            io_hold;
        logic            err;
        logic [15:0]     err_code;
    } pfs_state_s;

    pfs_state_s st;
    pfs_state_s next_st;
    pfs_instr_s ins;
    logic       cond;
    logic       push;
    logic       pop;
    logic       wdt_over;

    pfs_stack_if #(.AW(PC_W)) stk ();

    pfs_return_stack #(.AW(PC_W), .DEPTH(STACK_DEPTH)) u_stack (
        .clk_i (CLOCK_I),
        .rst_i (SYS_RST_I),
        .stk   (stk.owner)
    );

    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        sat_inc = (v == 8'hFF) ? v : 8'(v + 1'b1);
    endfunction : sat_inc

    function automatic pfs_state_s fail_to(input pfs_state_s s, input logic [15:0] code);
        fail_to          = s;
        fail_to.mode     = M_IDLE;
        fail_to.run      = 1'b0;
        fail_to.in_loop  = 1'b0;
        fail_to.skip     = SK_NONE;
        fail_to.err      = 1'b1;
        fail_to.err_code = code;
        fail_to.exec     = 1'b0;
    endfunction : fail_to

    // scan wraps to the top; what follows the end is never reached this way
    function automatic pfs_state_s end_scan(input pfs_state_s s);
        end_scan           = s;
        end_scan.pc        = '0;
        end_scan.scan_done = 1'b1;
        end_scan.ms_div    = '0;
        end_scan.scan_ms   = '0;
        end_scan.in_loop   = 1'b0;
        end_scan.skip      = SK_NONE;
    endfunction : end_scan

    assign ins  = pfs_instr_s'(IMEM_DATA_I);
    assign cond = !ins.contact || RUNG_TRUE_I;

    always_comb begin
        next_st           = st;
        next_st.exec      = 1'b0;
        next_st.scan_done = 1'b0;
        push              = 1'b0;
        pop               = 1'b0;

        // persistent watchdog setting; a value below the default is ignored
        if (CFG_CLEAR_I) begin
            next_st.wdt_ms = WDT_DEFAULT_MS;
        end else if (WDT_CFG_WE_I && WDT_CFG_MS_I >= WDT_DEFAULT_MS) begin
            next_st.wdt_ms = WDT_CFG_MS_I;
        end

        unique case (st.mode)
            M_IDLE: begin
                if (RUN_REQ_I) begin
                    next_st.mode      = M_CHK_F;
                    next_st.pc        = '0;
                    next_st.end_found = 1'b0;
                    next_st.end_bad   = 1'b0;
                    next_st.cnt_jump  = '0;
                    next_st.cnt_label = '0;
                    next_st.cnt_loop  = '0;
                    next_st.cnt_call  = '0;
                    next_st.cnt_sub   = '0;
                    next_st.err       = 1'b0;
                    next_st.err_code  = ERR_NONE;
                end
            end
            M_CHK_F: begin
                next_st.mode = M_CHK_E;
            end
            M_CHK_E: begin
                // first end closes the main body; count jumps, jump labels, loop starts, calls and subroutine labels
                case (ins.op)
                    OP_END: begin
                        if (!st.end_found) begin
                            next_st.end_found = 1'b1;
                            next_st.end_addr  = st.pc;
                            next_st.end_bad   = ins.contact;
                        end
                    end
                    OP_JUMP:             next_st.cnt_jump  = sat_inc(st.cnt_jump);
                    OP_JUMP_LABEL:       next_st.cnt_label = sat_inc(st.cnt_label);
                    OP_LOOP_START:       next_st.cnt_loop  = sat_inc(st.cnt_loop);
                    OP_SUBROUTINE_CALL:  next_st.cnt_call  = sat_inc(st.cnt_call);
                    OP_SUBROUTINE_LABEL: next_st.cnt_sub   = sat_inc(st.cnt_sub);
                    default: ;
                endcase
                if (st.pc != LAST_PC) begin
                    next_st.pc   = PC_W'(st.pc + 1'b1);
                    next_st.mode = M_CHK_F;
                end else if (!next_st.end_found || next_st.end_bad) begin
                    next_st = fail_to(next_st, ERR_END_BAD);
                end else if (next_st.cnt_loop > MAX_LOOP) begin
                    next_st = fail_to(next_st, ERR_LOOP_LIMIT);
                end else if (next_st.cnt_call > MAX_CALL
                             || next_st.cnt_sub > MAX_SUB_LABEL) begin
                    next_st = fail_to(next_st, ERR_SUB_LIMIT);
                end else if (next_st.cnt_jump > MAX_JUMP
                             || next_st.cnt_label > MAX_LABEL) begin
                    next_st = fail_to(next_st, ERR_JUMP_LIMIT);
                end else begin
                    next_st.mode    = M_RUN_F;
                    next_st.pc      = '0;
                    next_st.run     = 1'b1;
                    next_st.skip    = SK_NONE;
                    next_st.in_loop = 1'b0;
                    next_st.ms_div  = '0;
                    next_st.scan_ms = '0;
                end
            end
            M_RUN_F: begin
                next_st.mode = M_RUN_E;
            end
            M_RUN_E: begin
                next_st.mode = M_RUN_F;
                next_st.pc   = PC_W'(st.pc + 1'b1);
                if (ins.op == OP_END && st.skip != SK_SUB) begin
                    next_st = end_scan(next_st);
                end else if (st.skip == SK_LABEL) begin
                    if (ins.op == OP_JUMP_LABEL && ins.operand == st.key) begin
                        next_st.skip = SK_NONE;
                    end
                end else if (st.skip == SK_LOOP) begin
                    if (ins.op == OP_LOOP_END) begin
                        next_st.skip = SK_NONE;
                    end
                end else if (st.skip == SK_SUB) begin
                    if (ins.op == OP_SUBROUTINE_LABEL && ins.operand == st.key) begin
                        next_st.skip = SK_NONE;
                    end else if (st.pc == LAST_PC) begin
                        next_st = fail_to(next_st, ERR_SUB_LIMIT);
                    end
                end else begin
                    case (ins.op)
                        OP_NO_OPERATION: ;
                        OP_STOP: begin
                            if (cond) begin
                                next_st.mode    = M_IDLE;
                                next_st.run     = 1'b0;
                                next_st.in_loop = 1'b0;
                            end
                        end
                        OP_WATCHDOG_RESTART: begin
                            if (cond) begin
                                next_st.ms_div  = '0;
                                next_st.scan_ms = '0;
                            end
                        end
                        OP_JUMP: begin
                            if (cond) begin
                                next_st.skip = SK_LABEL;
                                next_st.key  = ins.operand;
                            end
                        end
                        OP_LOOP_START: begin
                            if (st.in_loop) begin
                                next_st = fail_to(next_st, ERR_LOOP_LIMIT);
                            end else if (cond && ins.operand != '0) begin
                                next_st.in_loop    = 1'b1;
                                next_st.loop_start = PC_W'(st.pc + 1'b1);
                                next_st.loop_left  = ins.operand;
                            end else begin
                                next_st.skip = SK_LOOP;
                            end
                        end
                        OP_LOOP_END: begin
                            if (st.in_loop && st.loop_left > 16'h0001) begin
                                next_st.loop_left = 16'(st.loop_left - 1'b1);
                                next_st.pc        = st.loop_start;
                            end else begin
                                next_st.in_loop = 1'b0;
                            end
                        end
                        OP_SUBROUTINE_CALL: begin
                            if (cond) begin
                                if (stk.full || st.end_addr == LAST_PC) begin
                                    next_st = fail_to(next_st, ERR_SUB_LIMIT);
                                end else begin
                                    push         = 1'b1;
                                    next_st.skip = SK_SUB;
                                    next_st.key  = ins.operand;
                                    next_st.pc   = PC_W'(st.end_addr + 1'b1);
                                end
                            end
                        end
                        OP_SUBROUTINE_RETURN: begin
                            // a stray return with nothing stacked is ignored
                            if (!stk.empty) begin
                                pop        = 1'b1;
                                next_st.pc = stk.top;
                            end
                        end
                        OP_SUBROUTINE_RETURN_COND: begin
                            if (cond && !stk.empty) begin
                                pop        = 1'b1;
                                next_st.pc = stk.top;
                            end
                        end
                        OP_END, OP_JUMP_LABEL, OP_SUBROUTINE_LABEL: ;
                        default: begin
                            next_st.exec = 1'b1;
                        end
                    endcase
                end
            end
            default: begin
                next_st = fail_to(next_st, ERR_NONE);
            end
        endcase

        // watchdog runs across the whole scan, loops and subroutines included
        if (st.run) begin
            if (st.scan_ms > {1'b0, st.wdt_ms}) begin
                next_st = fail_to(next_st, ERR_WDT);
            end else if (next_st.ms_div == st.ms_div) begin
                if (st.ms_div == 32'(MS_CYCLES - 1)) begin
                    next_st.ms_div = '0;
                    if (st.scan_ms != '1) begin
                        next_st.scan_ms = 17'(st.scan_ms + 1'b1);
                    end
                end else begin
                    next_st.ms_div = 32'(st.ms_div + 1'b1);
                end
            end
        end
        next_st.io_hold = next_st.in_loop;
    end

    assign stk.push      = push;
    assign stk.pop       = pop;
    assign stk.clear     = (st.mode == M_IDLE);
    assign stk.push_data = PC_W'(st.pc + 1'b1);
    assign wdt_over      = st.run && st.scan_ms > {1'b0, st.wdt_ms};

    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            st        <= '0;
            st.wdt_ms <= WDT_DEFAULT_MS;
        end else begin
            st <= next_st;
        end
    end

    assign IMEM_ADDR_O  = st.pc;
    assign RUN_O        = st.run;
    assign EXEC_O       = st.exec;
    assign SCAN_DONE_O  = st.scan_done;
    assign IO_HOLD_O    = st.io_hold;
    assign ERROR_O      = st.err;
    assign ERROR_CODE_O = st.err_code;

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (SYS_RST_I);

    sequence s_exec(pfs_op_e o);
        st.mode == M_RUN_E && st.skip == SK_NONE && ins.op == o;
    endsequence

    chk_run_needs_end: assert property (
        $rose(RUN_O) |-> st.end_found && !st.end_bad && !ERROR_O)
        else $error("run entered without a clean end");
    chk_end_contact: assert property (
        st.mode == M_CHK_E && st.pc == LAST_PC && (st.end_bad || (ins.op == OP_END
        && !st.end_found && ins.contact)) |=> !RUN_O && ERROR_CODE_O == ERR_END_BAD)
        else $error("end with contact not refused");
    chk_stop_mode: assert property (
        s_exec(OP_STOP) ##0 cond && !SYS_RST_I |=> !RUN_O && st.mode == M_IDLE)
        else $error("stop did not leave run");
    chk_wdt_default: assert property (
        CFG_CLEAR_I |=> st.wdt_ms == 16'h00C8)
        else $error("watchdog not back to default");
    chk_wdt_restart: assert property (
        s_exec(OP_WATCHDOG_RESTART) ##0 cond && !wdt_over |=>
        st.scan_ms == '0 ##1 st.scan_ms == '0)
        else $error("scan timer not cleared");
    chk_wdt_timeout: assert property (
        wdt_over |=> !RUN_O && ERROR_O && ERROR_CODE_O == 16'h0003)
        else $error("watchdog timeout missed");
    chk_wdt_raise: assert property (
        WDT_CFG_WE_I && !CFG_CLEAR_I && WDT_CFG_MS_I >= WDT_DEFAULT_MS
        |=> st.wdt_ms == $past(WDT_CFG_MS_I))
        else $error("watchdog setting not raised");
    chk_jump_skip: assert property (
        EXEC_O |-> $past(st.skip) == SK_NONE && $past(st.mode) == M_RUN_E)
        else $error("skipped instruction executed");
    chk_loop_skip: assert property (
        s_exec(OP_LOOP_START) ##0 !st.in_loop && !wdt_over
        && (!cond || ins.operand == '0) |=> st.skip == SK_LOOP && !IO_HOLD_O)
        else $error("disabled loop not skipped");
    chk_loop_nest: assert property (
        s_exec(OP_LOOP_START) ##0 st.in_loop && !wdt_over |=> ERROR_CODE_O == ERR_LOOP_LIMIT)
        else $error("nested loop not refused");
    chk_io_hold: assert property (
        SCAN_DONE_O |-> !IO_HOLD_O)
        else $error("scan ended with I/O held");
    chk_nest_limit: assert property (
        s_exec(OP_SUBROUTINE_CALL) ##0 cond && stk.full && !wdt_over |=> ERROR_CODE_O == 16'h0412)
        else $error("call nesting limit missed");
    chk_return_addr: assert property (
        s_exec(OP_SUBROUTINE_RETURN) ##0 !stk.empty && !wdt_over
        |=> IMEM_ADDR_O == $past(stk.top) ##1 st.mode == M_RUN_E)
        else $error("return went to wrong address");
    chk_no_operation: assert property (
        s_exec(OP_NO_OPERATION) ##0 !wdt_over
        |=> IMEM_ADDR_O == $past(st.pc) + 1'b1 && !EXEC_O && $stable(st.skip))
        else $error("empty location changed state");
endmodule : pfs_sequencer

// ---- tb/test_program_flow_sequencer.sv ----
// self-checking bench of the program flow sequencer against a small flow model
`timescale 1ns/1ps
module test_program_flow_sequencer;
    import pfs_pkg::*;
    localparam int MSC = 10;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic               run_req = 1'b0;
    logic               cfg_clr = 1'b0;
    logic               cfg_we = 1'b0;
    logic [15:0]        cfg_ms = 16'h0000;
    logic [INSTR_W-1:0] data = '0;
    logic [INSTR_W-1:0] mem [16];
    logic [3:0]         addr;
    logic               run, exec, done, hold, err, seen_hold, exp_h;
    logic               rung = 1'b1;
    logic [15:0]        code, s;
    logic [31:0]        seed = 32'd21;
    int                 bad_count = 0, n_tests = 0, cyc = 0, nx = 0, t, k, exp_n;
    pfs_sequencer #(.PC_W(4), .MS_CYCLES(MSC)) u_pfs_sequencer (.CLOCK_I(clk),
        .SYS_RST_I(rst), .RUN_REQ_I(run_req), .RUNG_TRUE_I(rung), .IMEM_DATA_I(data),
        .CFG_CLEAR_I(cfg_clr), .WDT_CFG_WE_I(cfg_we), .WDT_CFG_MS_I(cfg_ms),
        .IMEM_ADDR_O(addr), .RUN_O(run), .EXEC_O(exec), .SCAN_DONE_O(done),
        .IO_HOLD_O(hold), .ERROR_O(err), .ERROR_CODE_O(code));
    always #2.5 clk = ~clk;
    // memory answers on the falling edge, half a cycle after the address appears
    always @(negedge clk) data <= mem[addr];
    always @(posedge clk) begin
        cyc++;
        if (exec === 1'b1) nx++;
        if (hold === 1'b1) seen_hold = 1'b1;
        if (cyc > 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // flow model of one scan: logic steps run, and whether a loop body ran
    function automatic int model_scan(input logic r, output logic h);
        int          pc = 0, n = 0, left = 0, top = 0, e = 0, steps = 0, skip = -1;
        int          ret [$];
        logic [3:0]  op;
        logic        c, q;
        logic [15:0] v, key;
        h = 1'b0;
        while (e < 15 && mem[e][20:17] != OP_END) e++;
        while (steps < 400) begin
            {op, c, v} = mem[pc];
            pc = (pc + 1) % 16;
            steps++;
            q = !c || r;
            if (skip >= 0) begin
                if (op == OP_END && skip != OP_SUBROUTINE_LABEL) return n;
                if (op == skip && (op == OP_LOOP_END || v == key)) skip = -1;
                continue;
            end
            case (op)
                OP_END: return n;
                OP_JUMP, OP_SUBROUTINE_CALL: begin
                    if (q) begin
                        key  = v;
                        skip = (op == OP_JUMP) ? OP_JUMP_LABEL : OP_SUBROUTINE_LABEL;
                        if (op == OP_SUBROUTINE_CALL) begin
                            ret.push_back(pc);
                            pc = e + 1;
                        end
                    end
                end
                OP_LOOP_START: begin
                    if (q && v != 0) begin
                        left = v;
                        top  = pc;
                        h    = 1'b1;
                    end else begin
                        skip = OP_LOOP_END;
                    end
                end
                OP_LOOP_END: begin
                    if (left > 1) begin
                        left--;
                        pc = top;
                    end else begin
                        left = 0;
                    end
                end
                OP_SUBROUTINE_RETURN, OP_SUBROUTINE_RETURN_COND: begin
                    if ((q || op == OP_SUBROUTINE_RETURN) && ret.size() > 0) pc = ret.pop_back();
                end
                default: begin
                    if (op >= 4'hC) n++;
                end
            endcase
        end
        return n;
    endfunction : model_scan
    task automatic put(input int a, input pfs_op_e op, input logic c, input logic [15:0] v);
        mem[a] = {op, c, v};
    endtask : put
    task automatic wipe();
        for (int i = 0; i < 16; i++) mem[i] = '0;
    endtask : wipe
    task automatic check(input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (exp !== got) begin
            bad_count++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : check
    task automatic do_reset();
        @(negedge clk) rst = 1'b1;
        repeat (8) @(negedge clk);
        rst = 1'b0;
    endtask : do_reset
    task automatic start();
        @(negedge clk) run_req = 1'b1;
        @(negedge clk) run_req = 1'b0;
        t = 0;
        while (run !== 1'b1 && err !== 1'b1 && t < 200) begin
            @(negedge clk);
            t++;
        end
    endtask : start
    task automatic end_of_test();
        $display("mismatches %0d of %0d compares", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        wipe();
        put(0, OP_LOGIC, 1'b0, 16'h0000);
        do_reset();
        start();
        check(ERR_END_BAD, code);
        check(16'h0001, 16'(err));
        put(1, OP_END, 1'b1, 16'h0000);
        start();
        check(ERR_END_BAD, code);
        // loop count and rung drawn at random; both rung values get one scan each
        k = 1 + int'(xs() % 4);
        put(1, OP_JUMP, 1'b1, 16'h0001); put(2, OP_LOGIC, 1'b0, 16'h0000);
        put(3, OP_JUMP_LABEL, 1'b0, 16'h0001); put(4, OP_LOOP_START, 1'b1, 16'(k));
        put(5, OP_LOGIC, 1'b0, 16'h0000); put(6, OP_LOOP_END, 1'b0, 16'h0000);
        put(7, OP_SUBROUTINE_CALL, 1'b0, 16'h0002); put(8, OP_LOGIC, 1'b0, 16'h0000);
        put(9, OP_END, 1'b0, 16'h0000); put(10, OP_SUBROUTINE_LABEL, 1'b0, 16'h0002);
        put(11, OP_LOGIC, 1'b0, 16'h0000); put(12, OP_SUBROUTINE_RETURN_COND, 1'b1, 16'h0000);
        put(13, OP_WATCHDOG_RESTART, 1'b0, 16'h0000);
        put(14, OP_SUBROUTINE_RETURN, 1'b0, 16'h0000);
        start();
        check(16'h0001, 16'(run));
        rung = 1'(xs());
        for (int p = 0; p < 2; p++) begin
            nx = 0;
            seen_hold = 1'b0;
            t = 0;
            do begin
                @(negedge clk);
                t++;
            end while (done !== 1'b1 && t < 500);
            exp_n = model_scan(rung, exp_h);
            check(16'(exp_n), 16'(nx));
            check(16'(exp_h), 16'(seen_hold));
            rung = ~rung;
        end
        wipe();
        put(0, OP_STOP, 1'b1, 16'h0000); put(1, OP_END, 1'b0, 16'h0000);
        do_reset();
        rung = 1'b0;
        start();
        repeat (12) @(negedge clk);
        check(16'h0001, 16'(run));
        rung = 1'b1;
        repeat (12) @(negedge clk);
        check(16'h0000, 16'(run));
        check(16'h0000, 16'(err));
        // long loop overruns the watchdog; raised setting first, then a clear
        put(0, OP_LOOP_START, 1'b1, 16'h270F); put(1, OP_NO_OPERATION, 1'b0, 16'h0000);
        put(2, OP_LOOP_END, 1'b0, 16'h0000); put(3, OP_END, 1'b0, 16'h0000);
        for (int j = 0; j < 2; j++) begin
            // the clear comes with a write in the same cycle and must win
            cfg_ms = 16'(240 + xs() % 64);
            s = (j == 0) ? cfg_ms : WDT_DEFAULT_MS;
            cfg_clr = (j == 1);
            cfg_we = 1'b1;
            @(negedge clk);
            cfg_clr = 1'b0;
            cfg_we = 1'b0;
            start();
            t = 0;
            while (err !== 1'b1 && t < 4000) begin
                @(negedge clk);
                t++;
            end
            check(ERR_WDT, code);
            check(16'h0001, 16'(t >= s * MSC && t <= (s + 2) * MSC + 20));
        end
        end_of_test();
    end
endmodule : test_program_flow_sequencer
